// ===== hdl/umc_pkg.sv
// Constants for the serial mode-control block.
// Assumes a 32-bit APB slave port and one 50 MHz clock.
package umc_pkg;

    // Register byte offsets
    localparam logic [3:0]  UMC_OFF_MODE   = 4'h0;  // Mode register
    localparam logic [3:0]  UMC_OFF_MEAS   = 4'h4;  // Measured bit period

    // Mode register field positions
    localparam int          UMC_B_ENABLE   = 15;
    localparam int          UMC_B_STOPIDLE = 13;
    localparam int          UMC_B_INFRARED = 12;
    localparam int          UMC_B_RTSMODE  = 11;
    localparam int          UMC_B_USAGE    = 8;     // Two bits, 9:8
    localparam int          UMC_B_WAKE     = 7;
    localparam int          UMC_B_LOOP     = 6;
    localparam int          UMC_B_AUTOBAUD = 5;
    localparam int          UMC_B_RXINV    = 4;
    localparam int          UMC_B_HIGHSPD  = 3;
    localparam int          UMC_B_FORMAT   = 1;     // Two bits, 2:1
    localparam int          UMC_B_STOPSEL  = 0;

    // Reset value and writable bits (14 and 10 unimplemented)
    localparam logic [15:0] UMC_MODE_RST   = 16'h0000;
    localparam logic [15:0] UMC_MODE_WMASK = 16'hbbff;

    // Auto-baud: falling edges of a 0x55 sync field, and bits spanned
    localparam logic [2:0]  UMC_AB_EDGES   = 3'h5;
    localparam int          UMC_AB_SHIFT   = 3;     // Eight bit times
    localparam int          UMC_AB_CW      = 19;    // Cycle counter width

    // Pin ownership vector: {baud_clk, rts, cts, tx_rx}
    typedef logic [3:0] umc_own_t;

    // Pin-usage decode to owned pins
    function automatic umc_own_t umc_usage_own(input logic [1:0] usage);
        unique case (usage)
            2'b11:   umc_usage_own = 4'b1001;
            2'b10:   umc_usage_own = 4'b0111;
            2'b01:   umc_usage_own = 4'b0101;
            default: umc_usage_own = 4'b0001;
        endcase
    endfunction

endpackage

// ===== hdl/umc_rx_if.sv
// Carrier between the mode-control top and its receive-line watchers.
// Assumes every signal is in the pclk domain.
`timescale 1ns/1ps
interface umc_rx_if;
    logic                    rx_level;  // Synchronised line, idle high
    logic                    sleep;     // Chip in sleep
    logic                    wake_en;   // Wake-on-start armed
    logic                    wake_irq;  // Falling edge seen, pulse
    logic                    wake_clr;  // Following rising edge, pulse
    logic                    ab_en;     // Auto-baud armed and running
    logic                    ab_done;   // Measurement finished, pulse
    logic [15:0]             ab_period; // Cycles per bit

    modport top  (output rx_level, sleep, wake_en, ab_en,
                  input  wake_irq, wake_clr, ab_done, ab_period);
    modport wake (input  rx_level, sleep, wake_en,
                  output wake_irq, wake_clr);
    modport baud (input  rx_level, ab_en,
                  output ab_done, ab_period);
endinterface

// ===== hdl/umc_wake_detect.sv
// Wake-on-start watcher on the receive line during sleep.
// Assumes rx_level is already synchronised and polarity corrected.
`timescale 1ns/1ps
module umc_wake_detect
    import umc_pkg::*;
(
    // Clock and reset
    input  wire logic  pclk,
    input  wire logic  presetn,
    // Line watch
    umc_rx_if.wake     rx
);

    logic  prev_r;  // Previous line level
    logic  fall_r;  // Wake edge seen, awaiting rise
    logic  irq_r;   // Wake pulse
    logic  clr_r;   // Clear pulse

    // Line history for edge detection
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prev_r <= 1'b1;
        else
            prev_r <= rx.rx_level;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            fall_r <= 1'b0;
            irq_r  <= 1'b0;
        end
        else
        begin
            irq_r <= 1'b0;
            if (!rx.wake_en)
                fall_r <= 1'b0;         // Disarmed by software
            else if (!fall_r && rx.sleep && prev_r && !rx.rx_level)
            begin
                fall_r <= 1'b1;
                irq_r  <= 1'b1;
            end
            else if (clr_r)
                fall_r <= 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            clr_r <= 1'b0;
        else
            clr_r <= rx.wake_en && fall_r && !clr_r && !prev_r && rx.rx_level;
    end

    assign rx.wake_irq = irq_r;
    assign rx.wake_clr = clr_r;

    // Edge during sleep with wake armed
    sequence s_wake_fall;
        rx.wake_en && !fall_r && rx.sleep && prev_r && !rx.rx_level;
    endsequence

    property p_wake_irq;
        @(posedge pclk) disable iff (!presetn)
        s_wake_fall |=> irq_r ##1 !irq_r;
    endproperty
    a_wake_irq: assert property (p_wake_irq)
        else $error("wake pulse missing after sleep falling edge");

    property p_wake_clr;
        @(posedge pclk) disable iff (!presetn)
        clr_r |-> $past(fall_r) && $past(rx.rx_level) && !$past(prev_r);
    endproperty
    a_wake_clr: assert property (p_wake_clr)
        else $error("wake clear without preceding edge pair");

endmodule // umc_wake_detect

// ===== hdl/umc_autobaud.sv
// Auto-baud measurement over a 0x55 sync field.
// Assumes rx_level is synchronised, idle high, and ab_en is a level.
`timescale 1ns/1ps
module umc_autobaud
    import umc_pkg::*;
(
    // Clock and reset
    input  wire logic  pclk,
    input  wire logic  presetn,
    // Line watch
    umc_rx_if.baud     rx
);

    typedef enum logic [1:0] {UMC_AB_IDLE, UMC_AB_WAIT, UMC_AB_COUNT} umc_ab_e;

    umc_ab_e                  state_r;   // Measurement phase
    logic                     prev_r;    // Previous line level
    logic [2:0]               edges_r;   // Falling edges counted
    logic [UMC_AB_CW-1:0]     cnt_r;     // Cycles since start edge
    logic [15:0]              period_r;  // Result, cycles per bit
    logic                     done_r;    // Finish pulse
    logic                     fall;      // Falling edge this cycle

    assign fall = prev_r && !rx.rx_level;

    // Line history
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prev_r <= 1'b1;
        else
            prev_r <= rx.rx_level;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_r <= UMC_AB_IDLE;
            edges_r <= 3'h0;
            cnt_r   <= '0;
            done_r  <= 1'b0;
        end
        else
        begin
            done_r <= 1'b0;
            unique case (state_r)
                UMC_AB_IDLE:
                    if (rx.ab_en)
                        state_r <= UMC_AB_WAIT;
                UMC_AB_WAIT:
                    if (!rx.ab_en)
                        state_r <= UMC_AB_IDLE;
                    else if (fall)
                    begin
                        // Start bit edge opens the window
                        state_r <= UMC_AB_COUNT;
                        edges_r <= 3'h1;
                        cnt_r   <= '0;
                    end
                UMC_AB_COUNT:
                    if (!rx.ab_en)
                        state_r <= UMC_AB_IDLE;
                    else if (fall && edges_r == UMC_AB_EDGES - 3'h1)
                    begin
                        state_r <= UMC_AB_IDLE;
                        done_r  <= 1'b1;
                    end
                    else
                    begin
                        cnt_r <= cnt_r + 1'b1;
                        if (fall)
                            edges_r <= edges_r + 3'h1;
                    end
                // Unused code: fall back to idle
                default:
                    state_r <= UMC_AB_IDLE;
            endcase
        end
    end

    // Result: eight bit times divided down
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            period_r <= 16'h0000;
        else if (state_r == UMC_AB_COUNT && fall && edges_r == UMC_AB_EDGES - 3'h1)
            period_r <= cnt_r[UMC_AB_SHIFT +: 16];
    end

    assign rx.ab_done   = done_r;
    assign rx.ab_period = period_r;

    property p_ab_done_src;
        @(posedge pclk) disable iff (!presetn)
        done_r |-> $past(state_r == UMC_AB_COUNT) && $past(edges_r) == 3'h4;
    endproperty
    a_ab_done_src: assert property (p_ab_done_src)
        else $error("auto-baud finished without five falling edges");

endmodule // umc_autobaud

// ===== hdl/umc_top.sv
// Serial mode-control block: APB mode register, pin ownership,
// polarity, infrared path, loopback, wake-on-start and auto-baud.
// Assumes a 50 MHz pclk; baud generator and shift engines are outside.
`timescale 1ns/1ps
module umc_top
    import umc_pkg::*;
(
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [3:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Chip power state
    input  wire logic        chip_idle,
    input  wire logic        chip_sleep,
    // Serial pins
    input  wire logic        receive_pin,
    input  wire logic        clear_to_send_pin,
    output logic             transmit_pin_out,
    output logic             transmit_pin_oe,
    output logic             request_to_send_pin_out,
    output logic             request_to_send_pin_oe,
    output logic [3:0]       pin_owned,
    // Serial core side
    input  wire logic        core_tx_data,
    input  wire logic        core_baud_clk,
    input  wire logic        core_rx_ready,
    input  wire logic        core_tx_busy,
    output logic             core_rx_data,
    output logic             core_cts_ok,
    output logic             core_run,
    output logic             high_speed_baud,
    output logic [1:0]       parity_data_format,
    output logic             stop_bit_select,
    output logic             wake_irq,
    output logic [15:0]      measured_bit_cycles
);

    logic [15:0]  mode_r;       // Mode register
    logic         rx_s1_r;      // Receive sync, first stage
    logic         rx_s2_r;      // Receive sync, second stage
    logic         cts_s1_r;     // Clear-to-send sync, first stage
    logic         cts_s2_r;     // Clear-to-send sync, second stage
    logic         tx_r;         // Transmit pin level
    logic         rts_r;        // Request-to-send pin level
    logic         rx_data_r;    // Data toward receiver
    logic [31:0]  rdata_r;      // Read data
    logic         err_r;        // Unmapped access error
    logic         wr_mode;      // Mode write this cycle
    logic         module_enable;
    logic         infrared_enable;
    logic         loopback_enable;
    logic         rx_level;     // Line, polarity corrected
    umc_own_t     own;          // Owned pins while enabled

    umc_rx_if rx_if ();

    // Zero-wait slave, access phase completes at once
    assign pready  = 1'b1;
    assign pslverr = err_r & psel & penable;
    assign prdata  = rdata_r;
    assign wr_mode = psel && penable && pwrite && paddr == UMC_OFF_MODE;

    assign module_enable   = mode_r[UMC_B_ENABLE];
    assign infrared_enable = mode_r[UMC_B_INFRARED];
    assign loopback_enable = mode_r[UMC_B_LOOP];

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            mode_r <= UMC_MODE_RST;
        else
        begin
            if (wr_mode)
                mode_r <= pwdata[15:0] & UMC_MODE_WMASK;
            if (rx_if.wake_clr && !(wr_mode && pwdata[UMC_B_WAKE]))
                mode_r[UMC_B_WAKE] <= 1'b0;
            if (rx_if.ab_done && !(wr_mode && pwdata[UMC_B_AUTOBAUD]))
                mode_r[UMC_B_AUTOBAUD] <= 1'b0;
        end
    end

    // Read data, captured during the setup phase
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            rdata_r <= 32'h0000_0000;
            err_r   <= 1'b0;
        end
        else if (psel && !penable)
        begin
            rdata_r <= 32'h0000_0000;
            err_r   <= 1'b0;
            if (paddr == UMC_OFF_MODE)
                rdata_r[15:0] <= mode_r;        // Hardware clears show here
            else if (paddr == UMC_OFF_MEAS)
                rdata_r[15:0] <= rx_if.ab_period;
            else
                err_r <= 1'b1;                  // Unmapped: error, zero data
        end
    end

    // Pin synchronisers; first stages feed only second stages
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            rx_s1_r  <= 1'b1;
            rx_s2_r  <= 1'b1;
            cts_s1_r <= 1'b1;
            cts_s2_r <= 1'b1;
        end
        else
        begin
            rx_s1_r  <= receive_pin;
            rx_s2_r  <= rx_s1_r;
            cts_s1_r <= clear_to_send_pin;
            cts_s2_r <= cts_s1_r;
        end
    end

    // invert makes idle-low line read idle-high
    assign rx_level = rx_s2_r ^ mode_r[UMC_B_RXINV];

    // halt while idle if stop-in-idle set
    assign core_run = module_enable && !(chip_idle && mode_r[UMC_B_STOPIDLE]);

    assign own       = umc_usage_own(mode_r[UMC_B_USAGE +: 2]);
    assign pin_owned = module_enable ? own : 4'h0;

    // Transmit pin level
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            tx_r <= 1'b1;
        else if (loopback_enable || !core_run)
            tx_r <= 1'b1;
        // infrared pulse for each zero bit
        else if (infrared_enable)
            tx_r <= !core_tx_data && core_baud_clk;
        else
            tx_r <= core_tx_data;
    end

    // Receive data toward the receiver
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            rx_data_r <= 1'b1;
        else if (loopback_enable)
            rx_data_r <= core_tx_data;
        else if (infrared_enable)
            rx_data_r <= !rx_level;
        else
            rx_data_r <= rx_level;
    end

    // Request-to-send pin, or baud clock when usage is 11
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            rts_r <= 1'b1;
        else if (own[3])
            rts_r <= core_baud_clk;
        else if (mode_r[UMC_B_RTSMODE])
            rts_r <= !core_tx_busy;
        else
            rts_r <= !core_rx_ready;
    end

    // Pin drivers; the enables track ownership
    assign transmit_pin_out        = tx_r;
    assign transmit_pin_oe         = pin_owned[0];
    assign request_to_send_pin_out = rts_r;
    assign request_to_send_pin_oe  = pin_owned[2] | pin_owned[3];
    assign core_rx_data            = rx_data_r;
    // CTS ignored unless owned; active low pin
    assign core_cts_ok = pin_owned[1] ? !cts_s2_r : 1'b1;

    assign high_speed_baud    = mode_r[UMC_B_HIGHSPD];
    assign parity_data_format = mode_r[UMC_B_FORMAT +: 2];
    assign stop_bit_select    = mode_r[UMC_B_STOPSEL];

    // Hand the line to the watchers
    assign rx_if.rx_level = rx_level;
    assign rx_if.sleep    = chip_sleep;
    // Wake watch runs even with the module halted
    assign rx_if.wake_en  = mode_r[UMC_B_WAKE];
    assign rx_if.ab_en    = mode_r[UMC_B_AUTOBAUD] && core_run;
    assign wake_irq            = rx_if.wake_irq;
    assign measured_bit_cycles = rx_if.ab_period;

    // Wake-on-start watcher
    umc_wake_detect u_wake (
        .pclk    (pclk),
        .presetn (presetn),
        .rx      (rx_if.wake)
    );

    // Sync field measurement
    umc_autobaud u_baud (
        .pclk    (pclk),
        .presetn (presetn),
        .rx      (rx_if.baud)
    );

    property p_release;
        @(posedge pclk) disable iff (!presetn)
        !module_enable |-> pin_owned == 4'h0 && !transmit_pin_oe && !core_run;
    endproperty
    a_release: assert property (p_release)
        else $error("pins held while disabled");

    property p_usage;
        @(posedge pclk) disable iff (!presetn)
        module_enable |-> pin_owned == umc_usage_own(mode_r[9:8]) && pin_owned[0];
    endproperty
    a_usage: assert property (p_usage)
        else $error("pin ownership differs from usage field");

    property p_usage_10;
        @(posedge pclk) disable iff (!presetn)
        module_enable && mode_r[9:8] == 2'b10 |-> pin_owned == 4'b0111;
    endproperty
    a_usage_10: assert property (p_usage_10)
        else $error("usage 10 did not take cts and rts");

    property p_idle_stop;
        @(posedge pclk) disable iff (!presetn)
        chip_idle && mode_r[13] |-> !core_run;
    endproperty
    a_idle_stop: assert property (p_idle_stop)
        else $error("block ran during idle with stop set");

    sequence s_loop_on;
        loopback_enable ##1 loopback_enable;
    endsequence

    property p_loop;
        @(posedge pclk) disable iff (!presetn)
        s_loop_on |-> core_rx_data == $past(core_tx_data) && tx_r;
    endproperty
    a_loop: assert property (p_loop)
        else $error("loopback path or idle pin wrong");

    property p_reserved;
        @(posedge pclk) disable iff (!presetn)
        psel && penable && !pwrite && paddr == UMC_OFF_MODE
            |-> prdata[14] == 1'b0 && prdata[10] == 1'b0 && prdata[31:16] == 16'h0000;
    endproperty
    a_reserved: assert property (p_reserved)
        else $error("unimplemented mode bits read non-zero");

    property p_ab_clear;
        @(posedge pclk) disable iff (!presetn)
        rx_if.ab_done && !wr_mode
            |=> !mode_r[5] ##1 (!mode_r[5] || $past(wr_mode && pwdata[UMC_B_AUTOBAUD]));
    endproperty
    a_ab_clear: assert property (p_ab_clear)
        else $error("auto-baud bit not cleared after measurement");

    property p_wake_clear;
        @(posedge pclk) disable iff (!presetn)
        rx_if.wake_clr && !wr_mode |=> !mode_r[7];
    endproperty
    a_wake_clear: assert property (p_wake_clear)
        else $error("wake bit not cleared on rising edge");

    property p_rts_flow;
        @(posedge pclk) disable iff (!presetn)
        !own[3] && !mode_r[11] |=> rts_r == !$past(core_rx_ready);
    endproperty
    a_rts_flow: assert property (p_rts_flow)
        else $error("flow-control rts does not track receiver");

    property p_infrared;
        @(posedge pclk) disable iff (!presetn)
        infrared_enable && !loopback_enable && core_run
            |=> tx_r == (!$past(core_tx_data) && $past(core_baud_clk));
    endproperty
    a_infrared: assert property (p_infrared)
        else $error("infrared encoder output wrong");

endmodule // umc_top

// ===== testbench/umc_line_model.sv
// Remote serial sender model driving the receive line.
// Assumes the bench clock; the line idles high through a pull-up.
`timescale 1ns/1ps
module umc_line_model
(
    // Clock
    input  wire logic pclk,
    // Serial line
    output logic      rx_line
);
    // Pull-up holds the line high outside frames
    initial rx_line = 1'b1;

    // Drive a level for n clocks; call just after a rising edge
    task automatic hold(input logic v, input int n);
        rx_line <= v;
        repeat (n) @(posedge pclk);
    endtask

    // sync field framing
    // Start bit, eight data bits LSB first, one stop bit
    task automatic send(input logic [7:0] b, input int n);
        hold(1'b0, n);
        for (int i = 0; i < 8; i++)
            hold(b[i], n);
        hold(1'b1, n);
    endtask
endmodule // umc_line_model

// ===== testbench/umc_top_tb.sv
// Self-checking bench for the serial mode-control block.
// Assumes the line model on the receive pin and a zero-wait APB slave.
`timescale 1ns/1ps
module umc_top_tb
    import umc_pkg::*;
;
    logic        pclk = 1'b0;        // 50 MHz clock
    logic        presetn = 1'b0;     // Held low at start
    logic        psel, penable, pwrite, pready, pslverr;
    logic [3:0]  paddr;
    logic [31:0] pwdata, prdata;
    logic        chip_idle, chip_sleep, cts, tx_d, bclk, rx_rdy, tx_busy;
    logic        rx_line, tx_out, tx_oe, rts_out, rts_oe, crx, cts_ok, run;
    logic        hs, ssel, wirq;
    logic [3:0]  own;
    logic [1:0]  pdf;
    logic [15:0] meas;
    int          bad_count = 0;      // Mismatches
    int          check_count = 0;    // Comparisons
    logic [32:0] exp_q[$];           // Expected {pslverr, prdata} per read
    logic [3:0]  own_tab[4] = '{4'b0001, 4'b0101, 4'b0111, 4'b1001};

    // Free-running clock
    always #10 pclk = ~pclk;

    umc_line_model line (.pclk(pclk), .rx_line(rx_line));

    umc_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .chip_idle(chip_idle),
        .chip_sleep(chip_sleep), .receive_pin(rx_line), .clear_to_send_pin(cts),
        .transmit_pin_out(tx_out), .transmit_pin_oe(tx_oe),
        .request_to_send_pin_out(rts_out), .request_to_send_pin_oe(rts_oe),
        .pin_owned(own), .core_tx_data(tx_d), .core_baud_clk(bclk),
        .core_rx_ready(rx_rdy), .core_tx_busy(tx_busy), .core_rx_data(crx),
        .core_cts_ok(cts_ok), .core_run(run), .high_speed_baud(hs),
        .parity_data_format(pdf), .stop_bit_select(ssel), .wake_irq(wirq),
        .measured_bit_cycles(meas));

    // Count and report one comparison
    task automatic chk(input logic [32:0] g, input logic [32:0] e);
        check_count++;
        if (g !== e)
        begin
            bad_count++;
            $display("[ERR] %0t got %h want %h", $time, g, e);
        end
    endtask

    // Verdict and end of run
    task automatic conclude;
        if (bad_count == 0 && check_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // Read completions take the oldest note off the queue
    always @(posedge pclk)
    begin
        if (psel && penable && pready && !pwrite && exp_q.size() > 0)
            chk({pslverr, prdata}, exp_q.pop_front());
    end

    // One APB transfer; request held until pready is seen high
    task automatic apb(input logic w, input logic [3:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        // A stuck slave ends the run as a mismatch
        if (n >= 20)
        begin
            bad_count++;
            conclude();
        end
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rd(input logic [3:0] a, input logic [32:0] e);
        exp_q.push_back(e);
        apb(1'b0, a, 32'h0);
    endtask

    // Let synchronisers and registered outputs land
    task automatic settle;
        repeat (4) @(posedge pclk);
        @(negedge pclk);
    endtask

    // Main sequence
    initial
    begin
        logic [15:0] m;
        logic [31:0] r;
        int          n;
        logic [6:0]  e;              // Expected pin ownership word
        void'($urandom(32'h42f4e0f2));
        {psel, penable, pwrite, paddr, pwdata} = '0;
        {chip_idle, chip_sleep, cts, tx_d, bclk, rx_rdy, tx_busy} = '0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        rd(UMC_OFF_MODE, 33'h0);
        settle();
        chk({own, tx_oe, rts_oe, run}, 33'h0);
        apb(1'b1, UMC_OFF_MODE, 32'hffffffff);
        rd(UMC_OFF_MODE, 33'h0bbff);
        rd(4'h8, 33'h100000000);
        // Every pin-usage code with random format bits
        for (int u = 0; u < 4; u++)
        begin
            r = $urandom;
            // Random request-to-send mode covers both pin behaviours
            m = {4'b1000, r[7], 1'b0, u[1:0], 4'h0, r[3:0]};
            @(posedge pclk);
            cts     <= r[4];
            rx_rdy  <= r[5];
            tx_busy <= r[6];
            apb(1'b1, UMC_OFF_MODE, {16'h0, m});
            rd(UMC_OFF_MODE, {17'h0, m});
            settle();
            e = {own_tab[u], u != 0, 1'b1, (u == 2) ? !r[4] : 1'b1};
            chk({own, rts_oe, tx_oe, cts_ok}, e);
            // Usage 11 shows the baud clock; else simplex or flow control
            chk(rts_out, (u == 3) ? bclk : (r[7] ? !r[6] : !r[5]));
            chk({hs, pdf, ssel}, m[3:0]);
        end
        apb(1'b1, UMC_OFF_MODE, 32'ha000);
        @(posedge pclk);
        chip_idle <= 1'b1;
        settle();
        chk(run, 1'b0);
        apb(1'b1, UMC_OFF_MODE, 32'h8000);
        settle();
        chk({run, tx_out}, 2'b10);
        apb(1'b1, UMC_OFF_MODE, 32'h9000);
        @(posedge pclk);
        bclk <= 1'b1;
        settle();
        chk(tx_out, 1'b1);
        apb(1'b1, UMC_OFF_MODE, 32'h8040);
        for (int k = 0; k < 4; k++)
        begin
            r = $urandom;
            @(posedge pclk);
            tx_d <= r[0];
            settle();
            chk({crx, tx_out}, {r[0], 1'b1});
        end
        apb(1'b1, UMC_OFF_MODE, 32'h8010);
        settle();
        chk(crx, 1'b0);
        @(posedge pclk);
        line.hold(1'b0, 1);
        settle();
        chk(crx, 1'b1);
        @(posedge pclk);
        line.hold(1'b1, 1);
        // Wake watch during sleep, block left disabled
        apb(1'b1, UMC_OFF_MODE, 32'h0080);
        @(posedge pclk);
        chip_sleep <= 1'b1;
        settle();
        @(posedge pclk);
        line.hold(1'b0, 1);
        n = 0;
        while (wirq !== 1'b1 && n < 10)
        begin
            @(negedge pclk);
            n++;
        end
        chk(n < 10, 1'b1);
        @(negedge pclk);
        chk(wirq, 1'b0);
        @(posedge pclk);
        line.hold(1'b1, 1);
        settle();
        rd(UMC_OFF_MODE, 33'h0);
        apb(1'b1, UMC_OFF_MODE, 32'h8020);
        @(posedge pclk);
        chip_sleep <= 1'b0;
        line.send(8'h55, 16);
        settle();
        rd(UMC_OFF_MODE, 33'h08000);
        // Sync field spans 128 cycles; count stops one short, then divides by 8
        rd(UMC_OFF_MEAS, 33'h0000f);
        chk(meas, 16'h000f);
        conclude();
    end
endmodule // umc_top_tb
